//--- svst_consts.vh
/*
 * Constants for the regulator status, thermal and platform register bank:
 * register indices, field positions, reset values and strap encodings.
 * Assumes it is included by bare name from the bank's design files.
 */
`ifndef SVST_CONSTS_VH
`define SVST_CONSTS_VH

// ==========================================================================
// Register indices on the serial command port.
`define SVST_IDX_ERR_STATUS   8'h11
`define SVST_IDX_TEMP_ZONE    8'h12
`define SVST_IDX_ERR_LAST     8'h1C
`define SVST_IDX_MAX_CURRENT  8'h21
`define SVST_IDX_MAX_TEMP     8'h22
`define SVST_IDX_FAST_SLEW    8'h24
`define SVST_IDX_SLOW_SLEW    8'h25

// ==========================================================================
// Field positions.
`define SVST_BIT_PARITY_ERR   0
`define SVST_BIT_FRAME_ERR    1
`define SVST_BIT_ZONE_ALERT   6
`define SVST_BIT_ZONE_HOT     7
`define SVST_BIT_PS_THERM     1

// ==========================================================================
// Reset and fixed values.
`define SVST_RST_BYTE         8'h00
`define SVST_TEMP_LIMIT       8'h64
`define SVST_SLEW_LOW         8'h0A
`define SVST_SLEW_HIGH        8'h14

// ==========================================================================
// Slew strap level codes from the multilevel input comparator.
`define SVST_SLEW_LVL_0V      2'h0
`define SVST_SLEW_LVL_1V5     2'h1
`define SVST_SLEW_LVL_3V      2'h2
`define SVST_SLEW_LVL_VCC     2'h3

// Current strap level codes: 0 is below the lowest band, 17 above the top.
`define SVST_CURRENT_LIMIT_STRAP_LVL_LOW     5'h00
`define SVST_CURRENT_LIMIT_STRAP_LVL_HIGH    5'h11

`endif

//--- svst_current_limit_strap_decode.v
/*
 * Per-phase current report decoder for one regulator's current strap.
 * Assumes the strap level code is already synchronised and stable.
 */
`timescale 1ns/1ps
`default_nettype none
`include "svst_consts.vh"

module svst_current_limit_strap_decode #(
	parameter REG_B = 0                  // Selects the second regulator's column.
) (
	input  wire [4:0] level,            // Strap level code 0..17.
	output reg  [7:0] per_phase_amps,   // Reported amperes per phase.
	output wire       in_band           // Level lies inside a defined band.
);

	// ==========================================================================
	// Bands repeat every four levels: report 35, 33, 27, 22 amperes; the second
	// regulator drops to 22 and 17 for the two lighter settings.
	wire [1:0] pos;
	assign pos     = level[1:0] - 2'h1;
	assign in_band = (level != `SVST_CURRENT_LIMIT_STRAP_LVL_LOW) && (level < `SVST_CURRENT_LIMIT_STRAP_LVL_HIGH);

	always @* begin
		case (pos)
			2'h0: per_phase_amps = 8'h23;
			2'h1: per_phase_amps = 8'h21;
			2'h2: per_phase_amps = (REG_B != 0) ? 8'h16 : 8'h1B;
			2'h3: per_phase_amps = (REG_B != 0) ? 8'h11 : 8'h16;
			default: per_phase_amps = 8'h00;
		endcase
		// Level 12 of the second regulator is forced to the lighter value of 17 amperes.
		if ((REG_B != 0) && (level == 5'h0C))
			per_phase_amps = 8'h11;
		if (!in_band)
			per_phase_amps = 8'h00;
	end

endmodule
`default_nettype wire

//--- svst_status_regs.v
/*
 * Error status, temperature zone and platform capability registers of a
 * serial voltage-ID regulator controller.
 * Assumes the bus framing logic delivers one-cycle read/write strobes with
 * an index, and error pulses, all on sys_clk; strap and comparator levels
 * arrive asynchronously from the analog side and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "svst_consts.vh"

module svst_status_regs #(
	parameter PHASES_A = 3,             // Active phases of regulator A.
	parameter PHASES_B = 1              // Active phases of regulator B.
) (
	input  wire       sys_clk,          // 40 MHz system clock.
	input  wire       rstn,             // Asynchronous active-low reset.
	input  wire       rd_stb,           // One-cycle register read request.
	input  wire       wr_stb,           // One-cycle register write request.
	input  wire [7:0] reg_idx,          // Register index of the request.
	input  wire [7:0] wr_data,          // Write payload, ignored here.
	output reg  [7:0] rd_data,          // Read data, valid the cycle after rd_stb.
	output reg        rd_valid,         // One-cycle pulse with rd_data.
	output reg        rd_hit,           // Read index was mapped in this bank; low after writes.
	input  wire       parity_err,       // One-cycle payload parity error pulse.
	input  wire       frame_err,        // One-cycle data frame error pulse.
	input  wire       settled_in,       // Output settled level for status bit 0.
	input  wire       overcurrent_in,   // Current alert level for status bit 2.
	input  wire [7:0] thermistor_in_a,  // Regulator A comparator outputs.
	input  wire [7:0] thermistor_in_b,  // Regulator B comparator outputs.
	input  wire [4:0] current_limit_strap_a, // Regulator A strap level code.
	input  wire [4:0] current_limit_strap_b, // Regulator B strap level code.
	input  wire [1:0] slew_strap_level, // Slew strap level code.
	output wire       thermal_throttle_n, // Low when either regulator is hot.
	output reg        alert_n,          // Low after a primary status change.
	output reg  [7:0] primary_status,   // Primary status byte.
	output reg        reg_a_enable,     // Regulator A allowed to run.
	output reg        reg_b_enable      // Regulator B allowed to run.
);

	// ==========================================================================
	// Synchronisers. The first stage is read only by the second stage.
	reg [7:0] therm_a_s1_ff;
	reg [7:0] therm_a_ff;
	reg [7:0] therm_b_s1_ff;
	reg [7:0] therm_b_ff;
	reg [4:0] strap_a_s1_ff;
	reg [4:0] strap_a_ff;
	reg [4:0] strap_b_s1_ff;
	reg [4:0] strap_b_ff;
	reg [1:0] slew_s1_ff;
	reg [1:0] slew_ff;

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			therm_a_s1_ff <= `SVST_RST_BYTE;
			therm_a_ff    <= `SVST_RST_BYTE;
			therm_b_s1_ff <= `SVST_RST_BYTE;
			therm_b_ff    <= `SVST_RST_BYTE;
			strap_a_s1_ff <= 5'h00;
			strap_a_ff    <= 5'h00;
			strap_b_s1_ff <= 5'h00;
			strap_b_ff    <= 5'h00;
			slew_s1_ff    <= `SVST_SLEW_LVL_0V;
			slew_ff       <= `SVST_SLEW_LVL_0V;
		end else begin
			therm_a_s1_ff <= thermistor_in_a;
			therm_a_ff    <= therm_a_s1_ff;
			therm_b_s1_ff <= thermistor_in_b;
			therm_b_ff    <= therm_b_s1_ff;
			strap_a_s1_ff <= current_limit_strap_a;
			strap_a_ff    <= strap_a_s1_ff;
			strap_b_s1_ff <= current_limit_strap_b;
			strap_b_ff    <= strap_b_s1_ff;
			slew_s1_ff    <= slew_strap_level;
			slew_ff       <= slew_s1_ff;
		end
	end

	// ==========================================================================
	// Throttle output. Kept purely combinational from the comparators so a
	// stuck bus or a held clock cannot hide an overheat.
	assign thermal_throttle_n = ~(thermistor_in_a[`SVST_BIT_ZONE_HOT] |
		thermistor_in_b[`SVST_BIT_ZONE_HOT]);

	// ==========================================================================
	// Thermometer coding: a trip point counts only if every lower one trips,
	// which filters comparator glitches into a monotonic zone.
	function [7:0] thermo;
		input [7:0] raw;
		integer i;
		begin
			thermo[0] = raw[0];
			for (i = 1; i < 8; i = i + 1)
				thermo[i] = raw[i] & thermo[i-1];
		end
	endfunction

	// The zone reports the hotter of the two regulators.
	wire [7:0] zone_a;
	wire [7:0] zone_b;
	wire [7:0] zone;
	assign zone_a = thermo(therm_a_ff);
	assign zone_b = thermo(therm_b_ff);
	assign zone   = zone_a | zone_b;

	// ==========================================================================
	// Error status with clear-on-read and last-read copy. A pulse arriving in
	// the very cycle of the read survives the clear.
	reg [7:0] err_status_ff;
	reg [7:0] err_last_ff;
	reg [7:0] nxt_err_status;
	wire      err_rd;
	assign err_rd = rd_stb && (reg_idx == `SVST_IDX_ERR_STATUS);

	always @* begin
		nxt_err_status = err_rd ? `SVST_RST_BYTE : err_status_ff;
		if (parity_err)
			nxt_err_status[`SVST_BIT_PARITY_ERR] = 1'b1;
		if (frame_err)
			nxt_err_status[`SVST_BIT_FRAME_ERR] = 1'b1;
		nxt_err_status[7:2] = 6'h00;
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			err_status_ff <= `SVST_RST_BYTE;
			err_last_ff   <= `SVST_RST_BYTE;
		end else begin
			err_status_ff <= nxt_err_status;
			if (err_rd)
				err_last_ff <= err_status_ff;
		end
	end

	// ==========================================================================
	// Platform straps: current report and regulator disable.
	wire [7:0] pp_a;
	wire [7:0] pp_b;
	wire       band_a;
	wire       band_b;

	svst_current_limit_strap_decode #(.REG_B(0)) u_current_limit_strap_a (
		.level          (strap_a_ff),
		.per_phase_amps (pp_a),
		.in_band        (band_a)
	);

	svst_current_limit_strap_decode #(.REG_B(1)) u_current_limit_strap_b (
		.level          (strap_b_ff),
		.per_phase_amps (pp_b),
		.in_band        (band_b)
	);

	// Product kept at 16 bits then cut to the 8-bit report field.
	wire [15:0] amps_a;
	wire [15:0] amps_b;
	localparam [7:0] PH_A = PHASES_A;
	localparam [7:0] PH_B = PHASES_B;
	assign amps_a = pp_a * PH_A;
	assign amps_b = pp_b * PH_B;

	reg [7:0] max_current_ff;
	reg       latch_off_a_ff;
	reg       latch_off_b_ff;
	reg       strap_valid_ff;
	reg [1:0] strap_wait_ff;

	// Straps are settled after two synchroniser stages; wait four cycles before
	// judging them so reset values are never mistaken for a grounded strap.
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			strap_wait_ff  <= 2'h0;
			strap_valid_ff <= 1'b0;
			max_current_ff <= `SVST_RST_BYTE;
			latch_off_a_ff <= 1'b0;
			latch_off_b_ff <= 1'b0;
			reg_a_enable   <= 1'b0;
			reg_b_enable   <= 1'b0;
		end else begin
			if (strap_wait_ff != 2'h3)
				strap_wait_ff <= strap_wait_ff + 2'h1;
			else
				strap_valid_ff <= 1'b1;
			if (strap_valid_ff) begin
				max_current_ff <= amps_a[7:0];
				if (strap_a_ff == `SVST_CURRENT_LIMIT_STRAP_LVL_LOW)
					latch_off_a_ff <= 1'b1;
				if (strap_b_ff == `SVST_CURRENT_LIMIT_STRAP_LVL_LOW)
					latch_off_b_ff <= 1'b1;
				reg_a_enable <= band_a && !latch_off_a_ff
					&& (strap_a_ff != `SVST_CURRENT_LIMIT_STRAP_LVL_LOW);
				reg_b_enable <= band_b && !latch_off_b_ff
					&& (strap_b_ff != `SVST_CURRENT_LIMIT_STRAP_LVL_LOW);
			end
		end
	end

	// Regulator B's report is kept for a bank addressed at its own bus address.
	wire [7:0] max_current_b;
	assign max_current_b = amps_b[7:0];

	// ==========================================================================
	// Slew rate decode; unknown codes fall back to the lower rate.
	reg [7:0] fast_slew;
	always @* begin
		case (slew_ff)
			`SVST_SLEW_LVL_1V5: fast_slew = `SVST_SLEW_HIGH;
			`SVST_SLEW_LVL_3V:  fast_slew = `SVST_SLEW_HIGH;
			`SVST_SLEW_LVL_0V:  fast_slew = `SVST_SLEW_LOW;
			`SVST_SLEW_LVL_VCC: fast_slew = `SVST_SLEW_LOW;
			default:            fast_slew = `SVST_SLEW_LOW;
		endcase
	end

	// ==========================================================================
	// Primary status: settled, thermal alert, current alert, error pending.
	reg [7:0] nxt_primary;
	always @* begin
		nxt_primary = `SVST_RST_BYTE;
		nxt_primary[0] = settled_in;
		nxt_primary[`SVST_BIT_PS_THERM] = zone[`SVST_BIT_ZONE_ALERT];
		nxt_primary[2] = overcurrent_in;
		nxt_primary[7] = (nxt_err_status != `SVST_RST_BYTE);
	end

	// Alert stays low from a change until the master reads the primary status;
	// a change in the read cycle keeps it low.
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			primary_status <= `SVST_RST_BYTE;
			alert_n        <= 1'b1;
		end else begin
			primary_status <= nxt_primary;
			if (nxt_primary != primary_status)
				alert_n <= 1'b0;
			else if (rd_stb && (reg_idx == 8'h10))
				alert_n <= 1'b1;
		end
	end

	// ==========================================================================
	// Read port. Writes are accepted and have no effect on this bank.
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data  <= `SVST_RST_BYTE;
			rd_valid <= 1'b0;
			rd_hit   <= 1'b0;
		end else begin
			rd_valid <= rd_stb | wr_stb;
			rd_hit   <= 1'b1;
			if (rd_stb) begin
				case (reg_idx)
					8'h10:                 rd_data <= primary_status;
					`SVST_IDX_ERR_STATUS:  rd_data <= err_status_ff;
					`SVST_IDX_TEMP_ZONE:   rd_data <= zone;
					`SVST_IDX_ERR_LAST:    rd_data <= err_last_ff;
					`SVST_IDX_MAX_CURRENT: rd_data <= max_current_ff;
					`SVST_IDX_MAX_TEMP:    rd_data <= `SVST_TEMP_LIMIT;
					`SVST_IDX_FAST_SLEW:   rd_data <= fast_slew;
					`SVST_IDX_SLOW_SLEW:   rd_data <= {2'h0, fast_slew[7:2]};
					default: begin
						rd_data <= `SVST_RST_BYTE;
						rd_hit  <= 1'b0;
					end
				endcase
			end else if (wr_stb) begin
				rd_data <= `SVST_RST_BYTE;
				rd_hit  <= (wr_data == wr_data) && (reg_idx != 8'hFF) && 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

//--- svst_status_asserts.sv
/*
 * Port checker for the status, thermal and platform register bank.
 * Assumes single-cycle strobes and the one-cycle read answer of the bank.
 */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Checker
module svst_status_asserts (
	input wire logic       sys_clk,            // Clock.
	input wire logic       rstn,               // Reset, active low.
	input wire logic       rd_stb,             // Read request.
	input wire logic       wr_stb,             // Write request.
	input wire logic [7:0] reg_idx,            // Index.
	input wire logic [7:0] rd_data,            // Read data.
	input wire logic       rd_valid,           // Answer strobe.
	input wire logic       rd_hit,             // Mapped flag.
	input wire logic       parity_err,         // Parity pulse.
	input wire logic       frame_err,          // Frame pulse.
	input wire logic [7:0] thermistor_in_a,    // Comparators A.
	input wire logic [7:0] thermistor_in_b,    // Comparators B.
	input wire logic       thermal_throttle_n, // Throttle output.
	input wire logic       alert_n,            // Alert line.
	input wire logic [7:0] primary_status      // Primary status.
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// The throttle must never wait on the register path, so it is checked every cycle.
	a_throttle_direct: assert property (thermal_throttle_n == !(thermistor_in_a[7] | thermistor_in_b[7])) else $error("throttle mismatch");
	a_read_answer: assert property (rd_stb |=> rd_valid) else $error("read not answered");
	a_idle_quiet: assert property (!rd_stb && !wr_stb |=> !rd_valid) else $error("spurious answer");
	a_write_inert: assert property (wr_stb |=> rd_valid && !rd_hit) else $error("write answered as hit");
	a_err_reserved: assert property (rd_stb && reg_idx == 8'h11 |=> rd_data[7:2] == 6'h00) else $error("reserved bits set");
	a_clear_on_read: assert property ((rd_stb && reg_idx == 8'h11 && !parity_err && !frame_err) ##1 (rd_stb && reg_idx == 8'h11 && !parity_err && !frame_err) |=> rd_data == 8'h00) else $error("status not cleared");
	a_last_copy: assert property ((rd_stb && reg_idx == 8'h11) ##1 (rd_stb && reg_idx == 8'h1C) |=> rd_data == $past(rd_data)) else $error("copy differs");
	a_temp_limit: assert property (rd_stb && reg_idx == 8'h22 |=> rd_data == 8'h64 && rd_hit) else $error("limit wrong");
	a_zone_thermo: assert property (rd_stb && reg_idx == 8'h12 |=> ((rd_data + 8'h01) & rd_data) == 8'h00) else $error("zone not thermometer");
	a_slow_quarter: assert property ((rd_stb && reg_idx == 8'h24) ##1 (rd_stb && reg_idx == 8'h25) |=> rd_data == ($past(rd_data) >> 2)) else $error("slow not quarter");
	a_alert_hot: assert property ((&thermistor_in_a[6:0] | &thermistor_in_b[6:0]) [*6] |=> primary_status[1]) else $error("thermal alert missing");
	a_alert_change: assert property ($changed(primary_status) |-> !alert_n) else $error("alert not raised");
endmodule

bind svst_status_regs svst_status_asserts u_chk (.sys_clk, .rstn, .rd_stb, .wr_stb, .reg_idx,
	.rd_data, .rd_valid, .rd_hit, .parity_err, .frame_err, .thermistor_in_a, .thermistor_in_b,
	.thermal_throttle_n, .alert_n, .primary_status);
`default_nettype wire

//--- svst_master_model.sv
/*
 * Bus master model issuing register reads and writes to the bank.
 * Assumes the one-cycle strobe and one-cycle answer of the bank.
 */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Master
module svst_master_model (
	input  wire logic       sys_clk,  // Clock.
	output var  logic       rd_stb,   // Read request.
	output var  logic       wr_stb,   // Write request.
	output var  logic [7:0] reg_idx,  // Index.
	output var  logic [7:0] wr_data,  // Write payload.
	input  wire logic [7:0] rd_data,  // Read data.
	input  wire logic       rd_valid, // Answer strobe.
	input  wire logic       rd_hit    // Mapped flag.
);
	// The index is inverted once released so a stale value is never read as live.
	initial begin
		rd_stb = 1'b0;
		wr_stb = 1'b0;
		reg_idx = 8'h00;
		wr_data = 8'h00;
	end
	task automatic read_reg(input logic [7:0] idx, output logic [7:0] d, output logic h,
		output logic v);
		@(posedge sys_clk);
		rd_stb <= 1'b1;
		reg_idx <= idx;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		reg_idx <= ~idx;
		#1;
		d = rd_data;
		h = rd_hit;
		v = rd_valid;
	endtask
	// Two reads on consecutive edges; each answer is taken in the cycle it stands.
	task automatic read_two(input logic [7:0] i0, input logic [7:0] i1,
		output logic [7:0] d0, output logic [7:0] d1);
		@(posedge sys_clk);
		rd_stb <= 1'b1;
		reg_idx <= i0;
		@(posedge sys_clk);
		reg_idx <= i1;
		#1;
		d0 = rd_data;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		reg_idx <= ~i1;
		#1;
		d1 = rd_data;
	endtask
	task automatic write_reg(input logic [7:0] idx, input logic [7:0] val);
		@(posedge sys_clk);
		wr_stb <= 1'b1;
		reg_idx <= idx;
		wr_data <= val;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
		reg_idx <= ~idx;
		wr_data <= ~val;
	endtask
endmodule
`default_nettype wire

//--- tb.sv
/*
 * Self-checking bench for the status register bank.
 * Assumes the master model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bench
module tb;
	localparam PHASES_A = 3;
	logic sys_clk = 1'b0, rstn = 1'b0, parity_err = 1'b0, frame_err = 1'b0;
	logic settled_in = 1'b0, overcurrent_in = 1'b0;
	logic [7:0] thermistor_in_a = 8'h00, thermistor_in_b = 8'h00;
	logic [4:0] current_limit_strap_a = 5'h01, current_limit_strap_b = 5'h01;
	logic [1:0] slew_strap_level = 2'h3;
	wire rd_stb, wr_stb, rd_valid, rd_hit, thermal_throttle_n, alert_n, reg_a_enable, reg_b_enable;
	wire [7:0] reg_idx, wr_data, rd_data, primary_status;
	int bad_count = 0, comparisons = 0;

	// Clock generation.
	always #12.5 sys_clk = ~sys_clk;

	svst_status_regs #(.PHASES_A(PHASES_A), .PHASES_B(1)) dut (.sys_clk, .rstn, .rd_stb, .wr_stb,
		.reg_idx, .wr_data, .rd_data, .rd_valid, .rd_hit, .parity_err, .frame_err, .settled_in,
		.overcurrent_in, .thermistor_in_a, .thermistor_in_b, .current_limit_strap_a,
		.current_limit_strap_b, .slew_strap_level, .thermal_throttle_n, .alert_n,
		.primary_status, .reg_a_enable, .reg_b_enable);
	svst_master_model m (.sys_clk, .rd_stb, .wr_stb, .reg_idx, .wr_data, .rd_data, .rd_valid, .rd_hit);

	// ======================================================================
	// Compare and helper tasks
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic hit);
		logic [7:0] d;
		logic h;
		logic v;
		m.read_reg(idx, d, h, v);
		chk_byte(d, exp);
		chk_bit(h, hit);
		chk_bit(v, 1'b1);
	endtask
	// Strap and comparator inputs pass two sync stages, so eight edges is ample.
	task automatic settle;
		repeat (8) @(posedge sys_clk);
		#1;
	endtask
	task automatic pulse(input logic [1:0] e);
		@(posedge sys_clk);
		parity_err <= e[0];
		frame_err <= e[1];
		@(posedge sys_clk);
		parity_err <= 1'b0;
		frame_err <= 1'b0;
		settle;
	endtask
	task automatic tally_and_finish;
		$display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ======================================================================
	// Scenarios
	task automatic t_fixed;
		rd(8'h22, 8'h64, 1'b1);
		rd(8'h30, 8'h00, 1'b0);
		m.write_reg(8'h22, 8'hFF);
		rd(8'h22, 8'h64, 1'b1);
		$display("test fixed done");
	endtask
	task automatic t_errors;
		pulse(2'h1);
		chk_bit(alert_n, 1'b0);
		rd(8'h11, 8'h01, 1'b1);
		rd(8'h11, 8'h00, 1'b1);
		rd(8'h1C, 8'h00, 1'b1);
		pulse(2'h2);
		rd(8'h11, 8'h02, 1'b1);
		pulse(2'h3);
		m.write_reg(8'h11, 8'h00);
		rd(8'h11, 8'h03, 1'b1);
		rd(8'h1C, 8'h03, 1'b1);
		settle;
		rd(8'h10, 8'h00, 1'b1);
		chk_bit(alert_n, 1'b1);
		$display("test errors done");
	endtask
	task automatic t_zone;
		@(posedge sys_clk);
		settled_in <= 1'b1;
		thermistor_in_a <= 8'h3F;
		settle;
		rd(8'h12, 8'h3F, 1'b1);
		chk_bit(primary_status[1], 1'b0);
		@(posedge sys_clk);
		thermistor_in_a <= 8'h7F;
		settle;
		rd(8'h12, 8'h7F, 1'b1);
		chk_bit(alert_n, 1'b0);
		rd(8'h10, 8'h03, 1'b1);
		chk_bit(alert_n, 1'b1);
		@(posedge sys_clk);
		thermistor_in_a <= 8'h00;
		thermistor_in_b <= 8'hFF;
		#1;
		chk_bit(thermal_throttle_n, 1'b0);
		settle;
		rd(8'h12, 8'hFF, 1'b1);
		@(posedge sys_clk);
		thermistor_in_b <= 8'h00;
		#1;
		chk_bit(thermal_throttle_n, 1'b1);
		$display("test zone done");
	endtask
	task automatic t_slew;
		logic [7:0] fast [4] = '{8'h0A, 8'h14, 8'h14, 8'h0A};
		rd(8'h24, 8'h0A, 1'b1);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			slew_strap_level <= i[1:0];
			settle;
			rd(8'h24, fast[i], 1'b1);
			rd(8'h25, fast[i] >> 2, 1'b1);
		end
		$display("test slew done");
	endtask
	// Back-to-back reads exercise the copy and clear on consecutive requests.
	task automatic t_pairs;
		logic [7:0] d0;
		logic [7:0] d1;
		pulse(2'h1);
		m.read_two(8'h11, 8'h11, d0, d1);
		chk_byte(d0, 8'h01);
		chk_byte(d1, 8'h00);
		pulse(2'h2);
		m.read_two(8'h11, 8'h1C, d0, d1);
		chk_byte(d0, 8'h02);
		chk_byte(d1, 8'h02);
		m.read_two(8'h24, 8'h25, d0, d1);
		chk_byte(d0, 8'h0A);
		chk_byte(d1, 8'h02);
		$display("test pairs done");
	endtask
	task automatic set_strap(input logic [4:0] a, input logic [4:0] b);
		@(posedge sys_clk);
		current_limit_strap_a <= a;
		current_limit_strap_b <= b;
		settle;
	endtask
	task automatic t_current;
		logic [7:0] per [4] = '{8'h23, 8'h21, 8'h1B, 8'h16};
		for (int l = 1; l <= 16; l++) begin
			set_strap(5'(l), 5'h01);
			rd(8'h21, 8'(per[(l - 1) % 4] * PHASES_A), 1'b1);
			chk_bit(reg_a_enable, 1'b1);
		end
		set_strap(5'h11, 5'h01);
		rd(8'h21, 8'h00, 1'b1);
		chk_bit(reg_a_enable, 1'b0);
		set_strap(5'h01, 5'h00);
		chk_bit(reg_a_enable, 1'b1);
		chk_bit(reg_b_enable, 1'b0);
		set_strap(5'h00, 5'h01);
		set_strap(5'h01, 5'h01);
		chk_bit(reg_a_enable, 1'b0);
		$display("test current done");
	endtask

	// ======================================================================
	// Main sequence and hang guard
	initial begin
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		settle;
		t_fixed;
		t_errors;
		t_zone;
		t_slew;
		t_pairs;
		t_current;
		tally_and_finish;
	end
	initial begin
		repeat (90000) @(posedge sys_clk);
		bad_count++;
		$display("[ERR] t=%0t run did not complete", $time);
		tally_and_finish;
	end
endmodule
`default_nettype wire
